// File: core/ffr_fan_fault_ramp.sv
`timescale 1ns/1ps
// Overview of operation
// - writing clear_fan_fault zeroes the fan-fail status bits, except one with a new failure in that cycle; bit self-clears.
// - after a clear, a later detected failure sets status again.
// - in interrupt behaviour, clear_fan_fault also releases the fault output pin unless a new failure is seen in that cycle.
// - fault_pin_behaviour 0 is interrupt, 1 is comparator-style indication.
// - zero_duty_fault_check 0 suppresses detection at zero duty or ramping to zero.
// - zero_duty_fault_check 1 drops the zero-duty gating; only fault_check_at_full_only can then gate detection.
// - ramp field limits duty change: 3.125, 6.25, 12.5 %/s, or immediate.
// - fault_check_at_full_only 1 evaluates failure only at 100 percent duty.
// - pulse_stretch_en works only with 33Hz PWM selected; 0 off, 1 on.
// - clearing speed_input_two_monitor_en stops monitoring, clears its status and fault out, except an interrupt pin set by a new failure in that cycle.
// - clearing speed_input_one_monitor_en stops monitoring, clears its status and fault out, except an interrupt pin set by a new failure in that cycle.
// - after a fan failure the PWM duty follows the fault_duty_level register.
module ffr_fan_fault_ramp #(
	parameter int STEP_CYC = ffr_pkg::FFR_SLOW_STEP_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire ffr_pkg::ffr_reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] target_duty,
	input wire ffr_pkg::ffr_fail_s fail_raw,
	input wire logic fault_pin_behaviour,
	input wire logic pwm_33hz_sel,
	output logic [7:0] duty_out,
	output logic pulse_stretch_active,
	output ffr_pkg::ffr_fail_s fail_status,
	output logic fault_out_fullspeed_in_pin_o,
	output logic fault_out_fullspeed_in_pin_oe
);
	import ffr_pkg::*;

	logic [7:0] cfg_q;
	logic [7:0] fault_duty_level_q;
	logic clear_fan_fault;
	logic zero_duty_fault_check;
	logic fault_check_at_full_only;
	logic pulse_stretch_en;
	logic speed_input_one_monitor_en;
	logic speed_input_two_monitor_en;
	ffr_ramp_e ramp_sel;
	logic [7:0] duty_q;
	logic [31:0] tick_cnt_q;
	logic step_tick;
	logic [31:0] step_period;
	logic [7:0] goal;
	logic detect_ok;
	logic ramp_to_zero;
	logic cfg_wr;
	ffr_fail_s fail_q;
	logic fault_pin_q;
	logic any_fail;

	// address decode and next-state terms
	logic cfg_hit;
	logic duty_hit;
	logic [7:0] cfg_d;
	logic [7:0] fault_duty_level_d;
	logic [7:0] duty_d;
	logic [31:0] tick_cnt_d;

	// event and release terms of the status logic
	logic one_event;
	logic two_event;
	logic one_drop;
	logic two_drop;
	ffr_fail_s fail_d;

	// address match; shared by the write strobes and the read mux
	function automatic logic ffr_addr_hit(
		input logic [7:0] addr,
		input logic [7:0] reg_addr
	);
		return addr == reg_addr;
	endfunction

	assign cfg_hit = ffr_addr_hit(reg_req.addr, FFR_CFG_ADDR);
	assign duty_hit = ffr_addr_hit(reg_req.addr, FFR_DUTY_ADDR);
	assign cfg_wr = reg_req.wr && cfg_hit;
	assign clear_fan_fault = cfg_wr && reg_req.wdata[FFR_CLR_BIT];
	assign zero_duty_fault_check = cfg_q[FFR_ZERO_BIT];
	assign fault_check_at_full_only = cfg_q[FFR_FULL_BIT];
	assign pulse_stretch_en = cfg_q[FFR_PULSE_STRETCH_EN_BIT];
	assign speed_input_two_monitor_en = cfg_q[FFR_T2E_BIT];
	assign speed_input_one_monitor_en = cfg_q[FFR_T1E_BIT];
	assign ramp_sel = ffr_ramp_e'(cfg_q[FFR_RAMP_HI:FFR_RAMP_LO]);

	// config register; clear bit never stored so it always reads back 0
	always_comb begin
		cfg_d = cfg_q;
		if (cfg_wr) begin
			cfg_d = {1'b0, reg_req.wdata[6:0]};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_q <= FFR_CFG_RST;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// fault duty level is written whole; no field is reserved
	always_comb begin
		fault_duty_level_d = fault_duty_level_q;
		if (reg_req.wr && duty_hit) begin
			fault_duty_level_d = reg_req.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fault_duty_level_q <= FFR_DUTY_RST;
		end else begin
			fault_duty_level_q <= fault_duty_level_d;
		end
	end

	// reads have no side effect; the clear bit is a write-only strobe
	always_comb begin
		reg_rdata = 8'h00;
		if (cfg_hit) begin
			reg_rdata = cfg_q;
		end else if (duty_hit) begin
			reg_rdata = fault_duty_level_q;
		end
	end

	assign any_fail = fail_q.speed_one_fail || fail_q.speed_two_fail;
	// linear code-to-duty mapping: the level code is the duty code directly
	assign goal = any_fail ? fault_duty_level_q : target_duty;

	// ramp step period scales with the selected rate
	function automatic logic [31:0] ffr_step_period(input ffr_ramp_e sel);
		logic [31:0] per;
		per = 32'd1;
		unique case (sel)
			FFR_RAMP_SLOW: per = 32'(STEP_CYC);
			FFR_RAMP_SLOWMED: per = 32'(STEP_CYC / 2);
			FFR_RAMP_MEDFAST: per = 32'(STEP_CYC / 4);
			FFR_RAMP_FAST: per = 32'd1;
		endcase
		return per;
	endfunction

	assign step_period = ffr_step_period(ramp_sel);

	assign step_tick = (tick_cnt_q + 32'd1 >= step_period);

	// step timer restarts on every step so the rates stay exact
	always_comb begin
		tick_cnt_d = tick_cnt_q + 32'd1;
		if (step_tick) begin
			tick_cnt_d = 32'd0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tick_cnt_q <= 32'd0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	// one code per step; fast mode jumps straight to the goal
	always_comb begin
		duty_d = duty_q;
		if (ramp_sel == FFR_RAMP_FAST) begin
			duty_d = goal;
		end else if (step_tick && duty_q < goal) begin
			duty_d = duty_q + 8'd1;
		end else if (step_tick && duty_q > goal) begin
			duty_d = duty_q - 8'd1;
		end
	end

	// the slow rates trade response time for a quiet fan
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			duty_q <= FFR_DUTY_ZERO;
		end else begin
			duty_q <= duty_d;
		end
	end

	assign duty_out = duty_q;
	// stretch is ignored at other PWM rates to keep the fast drive clean
	assign pulse_stretch_active = pulse_stretch_en && pwm_33hz_sel == FFR_PWM_33HZ;

	assign ramp_to_zero = (goal == FFR_DUTY_ZERO);
	always_comb begin
		detect_ok = 1'b1;
		if (!zero_duty_fault_check && (duty_q == FFR_DUTY_ZERO || ramp_to_zero)) begin
			detect_ok = 1'b0;
		end
		if (fault_check_at_full_only && duty_q != FFR_DUTY_FULL) begin
			detect_ok = 1'b0;
		end
	end
	// with zero_duty_fault_check set, only the full-only check can gate

	// per-input failure event: raw flag seen while monitored and not gated
	function automatic logic ffr_fail_event(
		input logic raw,
		input logic mon_en,
		input logic gate_ok
	);
		logic hit;
		hit = 1'b0;
		if (mon_en && gate_ok) begin
			hit = raw;
		end
		return hit;
	endfunction

	// next value of one sticky status bit; a new failure wins over the clear
	function automatic logic ffr_fail_next(
		input logic cur,
		input logic mon_en,
		input logic event_hit,
		input logic clr
	);
		logic nxt;
		nxt = cur;
		if (!mon_en) begin
			nxt = 1'b0;
		end else if (event_hit) begin
			nxt = 1'b1;
		end else if (clr) begin
			nxt = 1'b0;
		end
		return nxt;
	endfunction

	// a config write that drops a monitor enable which was set
	function automatic logic ffr_en_drop(
		input logic cur_en,
		input logic wr_hit,
		input logic new_en
	);
		return cur_en && wr_hit && !new_en;
	endfunction

	assign one_event = ffr_fail_event(fail_raw.speed_one_fail, speed_input_one_monitor_en,
		detect_ok);
	assign two_event = ffr_fail_event(fail_raw.speed_two_fail, speed_input_two_monitor_en,
		detect_ok);
	assign one_drop = ffr_en_drop(speed_input_one_monitor_en, cfg_wr, reg_req.wdata[FFR_T1E_BIT]);
	assign two_drop = ffr_en_drop(speed_input_two_monitor_en, cfg_wr, reg_req.wdata[FFR_T2E_BIT]);

	always_comb begin
		fail_d = fail_q;
		fail_d.speed_one_fail = ffr_fail_next(fail_q.speed_one_fail, speed_input_one_monitor_en,
			one_event, clear_fan_fault);
		fail_d.speed_two_fail = ffr_fail_next(fail_q.speed_two_fail, speed_input_two_monitor_en,
			two_event, clear_fan_fault);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fail_q <= '0;
		end else begin
			fail_q <= fail_d;
		end
	end

	assign fail_status = fail_q;

	// comparator follows the next status so pin and status move on one edge;
	// interrupt latches a new event until a clear or a monitor enable drop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fault_pin_q <= 1'b0;
		end else if (fault_pin_behaviour) begin
			fault_pin_q <= fail_d.speed_one_fail || fail_d.speed_two_fail;
		end else if (one_event || two_event) begin
			fault_pin_q <= 1'b1;
		end else if (clear_fan_fault) begin
			fault_pin_q <= 1'b0;
		end else if (one_drop || two_drop) begin
			fault_pin_q <= 1'b0;
		end
	end

	// open drain: drive low only while asserting
	assign fault_out_fullspeed_in_pin_o = 1'b0;
	assign fault_out_fullspeed_in_pin_oe = fault_pin_q;
endmodule

// File: core/ffr_pkg.sv
package ffr_pkg;
	// register offsets
	localparam logic [7:0] FFR_CFG_ADDR = 8'h02;
	localparam logic [7:0] FFR_DUTY_ADDR = 8'h03;
	// config field positions
	localparam int FFR_CLR_BIT = 7;
	localparam int FFR_ZERO_BIT = 6;
	localparam int FFR_RAMP_HI = 5;
	localparam int FFR_RAMP_LO = 4;
	localparam int FFR_FULL_BIT = 3;
	localparam int FFR_PULSE_STRETCH_EN_BIT = 2;
	localparam int FFR_T2E_BIT = 1;
	localparam int FFR_T1E_BIT = 0;
	// reset values
	localparam logic [7:0] FFR_CFG_RST = 8'h03;
	localparam logic [7:0] FFR_DUTY_RST = 8'hff;
	localparam logic [7:0] FFR_DUTY_FULL = 8'hff;
	localparam logic [7:0] FFR_DUTY_ZERO = 8'h00;
	// timing: clock rate and base ramp step at 3.125 %/s of 255 codes
	localparam int FFR_CLK_HZ = 50000000;
	localparam int FFR_SLOW_MILLIPCT_PER_S = 3125;
	// one code is 100/255 %; step period = clk * (100/255) / (3.125)
	localparam int FFR_SLOW_STEP_CYC = int'((64'(FFR_CLK_HZ) * 100000) /
		(64'(255) * FFR_SLOW_MILLIPCT_PER_S));
	localparam logic [0:0] FFR_PWM_33HZ = 1'b1;

	typedef enum logic [1:0] {
		FFR_RAMP_SLOW = 2'b00,
		FFR_RAMP_SLOWMED = 2'b01,
		FFR_RAMP_MEDFAST = 2'b10,
		FFR_RAMP_FAST = 2'b11
	} ffr_ramp_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ffr_reg_req_s;

	typedef struct packed {
		logic speed_one_fail;
		logic speed_two_fail;
	} ffr_fail_s;
endpackage

// File: testbench/ffr_fan_model.sv
`timescale 1ns/1ps
module ffr_fan_model (
	input wire logic [7:0] duty,
	input wire logic [1:0] broken,
	output ffr_pkg::ffr_fail_s fail_raw
);
	import ffr_pkg::*;
	// an undriven fan stands still, so its speed sense reads as failed at zero duty
	// broken bit 0 is the first speed input, which sits in the upper struct field
	assign fail_raw = {broken[0], broken[1]} | {2{duty == 8'h00}};
endmodule

// File: testbench/ffr_fan_fault_ramp_sva.sv
`timescale 1ns/1ps
module ffr_fan_fault_ramp_sva (
	input wire logic clk,
	input wire logic sys_rst,
	input wire ffr_pkg::ffr_reg_req_s reg_req,
	input wire ffr_pkg::ffr_fail_s fail_raw,
	input wire logic fault_pin_behaviour,
	input wire logic [7:0] duty_out,
	input wire ffr_pkg::ffr_fail_s fail_status,
	input wire logic fault_out_fullspeed_in_pin_oe
);
	import ffr_pkg::*;
	logic [7:0] cfg_q, lvl_q;
	wire wcfg = reg_req.wr && reg_req.addr == FFR_CFG_ADDR;
	wire idle = fail_raw == 2'b00;
	wire fast_fail = cfg_q[5:4] == 2'b11 && fail_status != 2'b00;
	always_ff @(posedge clk) begin
		if (sys_rst) cfg_q <= FFR_CFG_RST;
		else if (wcfg) cfg_q <= reg_req.wdata & 8'h7f;
	end
	always_ff @(posedge clk) begin
		if (sys_rst) lvl_q <= FFR_DUTY_RST;
		else if (reg_req.wr && reg_req.addr == FFR_DUTY_ADDR) lvl_q <= reg_req.wdata;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_clr; wcfg && reg_req.wdata[7] && idle |=> fail_status == 2'b00; endproperty
	a_clr: assert property (p_clr) else $error("status kept after clear");
	property p_int; !fault_pin_behaviour && wcfg && reg_req.wdata[7] && idle
		|=> !fault_out_fullspeed_in_pin_oe; endproperty
	a_int: assert property (p_int) else $error("fault pin kept after clear");
	property p_ramp; $past(cfg_q[5:4]) != 2'b11
		|-> 8'(duty_out - $past(duty_out)) inside {8'h00, 8'h01, 8'hff}; endproperty
	a_ramp: assert property (p_ramp) else $error("duty stepped too far");
	property p_lvl; $past(fast_fail) |-> duty_out == $past(lvl_q); endproperty
	a_lvl: assert property (p_lvl) else $error("duty not at fault level");
	property p_zero; !cfg_q[6] && duty_out == 8'h00 && fail_status == 2'b00
		|=> fail_status == 2'b00; endproperty
	a_zero: assert property (p_zero) else $error("fail seen at zero duty");
	property p_set; cfg_q[6] && cfg_q[0] && !cfg_q[3] && fail_raw.speed_one_fail
		&& !reg_req.wr |=> fail_status.speed_one_fail; endproperty
	a_set: assert property (p_set) else $error("fail not latched");
	property p_full; cfg_q[3] && duty_out != FFR_DUTY_FULL && fail_status == 2'b00
		|=> fail_status == 2'b00; endproperty
	a_full: assert property (p_full) else $error("fail seen below full duty");
	property p_mon; wcfg && !reg_req.wdata[0] |=> ##1 !fail_status.speed_one_fail; endproperty
	a_mon: assert property (p_mon) else $error("status kept while unmonitored");
	c_clr: cover property (wcfg && reg_req.wdata[7]);
	c_fail: cover property (fail_status != 2'b00);
	c_fast: cover property (fast_fail);
endmodule
bind ffr_fan_fault_ramp ffr_fan_fault_ramp_sva u_sva (.*);

// File: testbench/testbench.sv
`timescale 1ns/1ps
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
	import ffr_pkg::*;
	logic clk = 0, sys_rst = 1, fpb = 0, p33 = 0, ps, oe;
	ffr_reg_req_s rq = '0;
	logic [7:0] tgt = 8'h80, duty, rdata, d0;
	logic [1:0] brk = 2'b00;
	ffr_fail_s raw, st;
	int err_total, n_checks, e, m_cfg = 3, m_lvl = 255;
	initial forever #10 clk = ~clk;
	ffr_fan_fault_ramp #(.STEP_CYC(8)) u_dut (.clk(clk), .sys_rst(sys_rst), .reg_req(rq),
		.reg_rdata(rdata), .target_duty(tgt), .fail_raw(raw), .fault_pin_behaviour(fpb),
		.pwm_33hz_sel(p33), .duty_out(duty), .pulse_stretch_active(ps), .fail_status(st),
		.fault_out_fullspeed_in_pin_o(), .fault_out_fullspeed_in_pin_oe(oe));
	ffr_fan_model u_fan (.duty(duty), .broken(brk), .fail_raw(raw));
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wt(1);
		rq = '{1'b1, 1'b0, a, d};
		wt(1);
		rq.wr = 1'b0;
		if (a == FFR_CFG_ADDR) m_cfg = d & 8'h7f;
		if (a == FFR_DUTY_ADDR) m_lvl = d;
	endtask
	task automatic rd(input logic [7:0] a, input int x);
		wt(1);
		rq.addr = a;
		#1 `CK(rdata, 8'(x))
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#100000 err_total++;
		results();
	end
	initial begin
		void'($urandom(91));
		wt(3);
		sys_rst = 0;
		rd(FFR_CFG_ADDR, m_cfg);
		rd(FFR_DUTY_ADDR, m_lvl);
		rd(8'h05, 0);
		wr(FFR_DUTY_ADDR, 8'($urandom_range(1, 254)));
		wr(FFR_CFG_ADDR, 8'hb3);
		rd(FFR_CFG_ADDR, m_cfg);
		$display("test registers done");
		brk = 2'b01;
		wt(2);
		`CK({st, oe, duty}, {2'b10, 1'b1, 8'(m_lvl)})
		brk = 2'b00;
		wr(FFR_CFG_ADDR, 8'hb3);
		`CK({st, oe}, 3'b000)
		brk = 2'b01;
		wt(1);
		`CK(st, 2'b10)
		fpb = 1;
		wt(1);
		`CK(oe, 1'b1)
		for (int i = 0; i < 2; i++) begin
			brk = 2'(1 << i);
			wr(FFR_CFG_ADDR, 8'h33);
			wt(1);
			`CK(st, {brk[0], brk[1]})
			wr(FFR_CFG_ADDR, 8'h33 ^ 8'(1 << i));
			wt(1);
			`CK({st, oe}, 3'b000)
		end
		$display("test fault done");
		brk = 2'b00;
		tgt = 8'h00;
		wr(FFR_CFG_ADDR, 8'hb3);
		wt(3);
		`CK(st, 2'b00)
		wr(FFR_CFG_ADDR, 8'h73);
		wt(1);
		`CK(st, 2'b11)
		tgt = 8'h80;
		wr(FFR_CFG_ADDR, 8'hbb);
		brk = 2'b01;
		wt(3);
		`CK(st, 2'b00)
		tgt = 8'hff;
		wt(3);
		`CK(st, 2'b10)
		$display("test detect gating done");
		brk = 2'b00;
		for (int r = 0; r < 3; r++) begin
			tgt = 8'h10;
			wr(FFR_CFG_ADDR, 8'hb3);
			wt(2);
			wr(FFR_CFG_ADDR, 8'h83 | 8'(r << 4));
			tgt = 8'hf0;
			d0 = duty;
			wt(64);
			e = 64 / (8 >> r);
			`CK((int'(duty) - int'(d0)) inside {[e - 1:e + 1]}, 1'b1)
		end
		for (int i = 0; i < 4; i++) begin
			wr(FFR_CFG_ADDR, 8'h33 | 8'((i & 1) << 2));
			p33 = i[1];
			#1 `CK(ps, 1'(i == 3))
		end
		$display("test ramp and stretch done");
		results();
	end
endmodule
